// file: verilog/t1_into_e1_frame_mapper.v
// Functional notes
// - Timeslot 0 of every outgoing 2048 kbit/s frame carries frame alignment and never tributary bits.
// - Each frame carries 193 tributary bits in order in timeslots 1-15, 17-25 and bit 1 of timeslot 26.
// - Timeslot 16 and timeslots 27-31 carry no tributary payload and are left for optional extra data.
// - Tributary bits pass untouched with no search for or alignment to any framing inside them.
// - With only the tributary carried, each outgoing clock is derived from the incoming signal of the other rate.
// - With reference-locked timing a two-frame slip buffer absorbs the rate difference.
// - A frame slip inserts or deletes exactly one whole frame while keeping delay small.
// - After a frame slip the buffer has ample margin before another slip is needed.
// - In timeslot-alignment mode a slip inserts or deletes eight consecutive bits.
`timescale 1ns/1ps
`include "t1_e1_map.vh"
module t1_into_e1_frame_mapper (
  input wire ref_clk,
  input wire arst_n,
  input wire ref_timing,
  input wire octet_mode,
  input wire t1_rx_bit,
  input wire t1_rx_en,
  input wire e1_rx_bit,
  input wire e1_rx_en,
  input wire e1_rx_sync,
  input wire ref_e1_en,
  input wire ref_t1_en,
  output reg e1_tx_bit,
  output reg e1_tx_en,
  output reg e1_tx_sync,
  output reg t1_tx_bit,
  output reg t1_tx_en,
  output reg map_slip,
  output reg demap_slip
);
  reg [`CREDIT_W-1:0] e1_credit_q;
  reg [`CREDIT_W-1:0] e1_credit_d;
  reg [`CREDIT_W-1:0] t1_credit_q;
  reg [`CREDIT_W-1:0] t1_credit_d;
  reg e1_tick;
  reg t1_tick;
  reg [7:0] tx_pos_q;
  reg tx_odd_q;
  reg [7:0] rx_pos_q;
  reg [7:0] rx_pos;
  reg tx_payload;
  reg rx_payload;
  reg tx_bit_d;
  wire map_rd_bit;
  wire demap_rd_bit;
  wire map_rep;
  wire map_del;
  wire demap_rep;
  wire demap_del;
  // Held as sized constants so single bits can be picked by position
  localparam [7:0] fas_word = `FAS_WORD;
  localparam [7:0] nfas_word = `NFAS_WORD;

  function is_payload;
    input [7:0] pos;
    reg [4:0] ts;
    begin
      ts = pos[7:3];
      is_payload = ((ts >= `TS_FIRST_LO) && (ts <= `TS_LAST_LO)) ||
                   ((ts >= `TS_FIRST_HI) && (ts <= `TS_LAST_HI)) ||
                   (pos == `TS26_BIT1);
    end
  endfunction

  // Credit counters give exact 256:193 bit ratios, so loop timing never slips
  always @*
  begin
    e1_credit_d = e1_credit_q;
    t1_credit_d = t1_credit_q;
    e1_tick = 1'b0;
    t1_tick = 1'b0;
    if (ref_timing)
      e1_tick = ref_e1_en;
    else
    begin
      if (t1_rx_en)
        e1_credit_d = e1_credit_d + `CREDIT_E1;
      if (e1_credit_d >= `CREDIT_T1)
      begin
        e1_credit_d = e1_credit_d - `CREDIT_T1;
        e1_tick = 1'b1;
      end
    end
    if (ref_timing)
      t1_tick = ref_t1_en;
    else
    begin
      if (e1_rx_en)
        t1_credit_d = t1_credit_d + `CREDIT_T1;
      if (t1_credit_d >= `CREDIT_E1)
      begin
        t1_credit_d = t1_credit_d - `CREDIT_E1;
        t1_tick = 1'b1;
      end
    end
  end

  always @*
  begin
    tx_payload = is_payload(tx_pos_q);
    rx_pos = e1_rx_sync ? 8'h00 : rx_pos_q;
    rx_payload = e1_rx_en && is_payload(rx_pos);
    if (tx_pos_q[7:3] == 5'd0)
      tx_bit_d = tx_odd_q ? nfas_word[~tx_pos_q[2:0]] : fas_word[~tx_pos_q[2:0]];
    else if (tx_payload)
      tx_bit_d = map_rd_bit;
    else
      tx_bit_d = `IDLE_BIT;
  end

  // Tributary side writes any bit as it comes; no framing search is done
  frame_slip_buffer map_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(t1_rx_en),
    .wr_bit(t1_rx_bit),
    .rd_en(e1_tick && tx_payload),
    .octet_mode(octet_mode),
    .rd_bit(map_rd_bit),
    .slip_repeat(map_rep),
    .slip_delete(map_del)
  );

  // Non-payload receive bits are never written, so TS26 bits 2-8 are dropped
  frame_slip_buffer demap_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(rx_payload),
    .wr_bit(e1_rx_bit),
    .rd_en(t1_tick),
    .octet_mode(octet_mode),
    .rd_bit(demap_rd_bit),
    .slip_repeat(demap_rep),
    .slip_delete(demap_del)
  );

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      e1_credit_q <= {`CREDIT_W{1'b0}};
      t1_credit_q <= {`CREDIT_W{1'b0}};
      tx_pos_q <= 8'h00;
      tx_odd_q <= 1'b0;
      rx_pos_q <= 8'h00;
      e1_tx_bit <= `IDLE_BIT;
      e1_tx_en <= 1'b0;
      e1_tx_sync <= 1'b0;
      t1_tx_bit <= 1'b0;
      t1_tx_en <= 1'b0;
      map_slip <= 1'b0;
      demap_slip <= 1'b0;
    end
    else
    begin
      e1_credit_q <= e1_credit_d;
      t1_credit_q <= t1_credit_d;
      e1_tx_en <= e1_tick;
      e1_tx_sync <= e1_tick && (tx_pos_q == 8'h00);
      t1_tx_en <= t1_tick;
      map_slip <= map_rep || map_del;
      demap_slip <= demap_rep || demap_del;
      if (e1_tick)
      begin
        e1_tx_bit <= tx_bit_d;
        tx_pos_q <= tx_pos_q + 8'h01;
        if (tx_pos_q == 8'hFF)
          tx_odd_q <= ~tx_odd_q;
      end
      if (t1_tick)
        t1_tx_bit <= demap_rd_bit;
      if (e1_rx_en)
        rx_pos_q <= rx_pos + 8'h01;
    end
  end
endmodule

// file: verilog/t1_e1_map.vh
`ifndef T1_E1_MAP_VH
`define T1_E1_MAP_VH
`define FRAME_BITS_W 8
`define PAYLOAD_BITS 9'd193
`define BUF_DEPTH 9'd386
`define BUF_LAST 9'd385
`define BUF_START 9'd193
`define OCTET_SLIP 9'd8
`define TS_AUX 5'd16
`define TS_FIRST_LO 5'd1
`define TS_LAST_LO 5'd15
`define TS_FIRST_HI 5'd17
`define TS_LAST_HI 5'd25
`define TS26_BIT1 8'hD0
`define FAS_WORD 8'h9B
`define NFAS_WORD 8'hDF
`define IDLE_BIT 1'b1
`define CREDIT_E1 10'd256
`define CREDIT_T1 10'd193
`define CREDIT_W 10
`endif

// file: verilog/frame_slip_buffer.v
`timescale 1ns/1ps
`include "t1_e1_map.vh"
module frame_slip_buffer (
  input wire ref_clk,
  input wire arst_n,
  input wire wr_en,
  input wire wr_bit,
  input wire rd_en,
  input wire octet_mode,
  output wire rd_bit,
  output reg slip_repeat,
  output reg slip_delete
);
  reg mem [0:385];
  reg [8:0] wr_q;
  reg [8:0] rd_q;
  reg [8:0] fill;
  reg [8:0] step;
  reg [8:0] rd_step;
  wire rd_last;
  wire wr_full;

  function [8:0] wrap_add;
    input [8:0] a;
    input [8:0] b;
    reg [9:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, `BUF_DEPTH})
        s = s - {1'b0, `BUF_DEPTH};
      wrap_add = s[8:0];
    end
  endfunction

  always @*
  begin
    if (wr_q >= rd_q)
      fill = wr_q - rd_q;
    else
      fill = wr_q + `BUF_DEPTH - rd_q;
    step = octet_mode ? `OCTET_SLIP : `PAYLOAD_BITS;
    rd_step = `BUF_DEPTH - step;
  end

  // Slip on the last held bit, so the empty write slot is never read out
  assign rd_last = (fill == 9'h001);
  assign wr_full = (fill == `BUF_LAST);
  assign rd_bit = mem[rd_q];

  always @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_q] <= wr_bit;
  end

  // Starting half full keeps delay one frame and leaves a frame of margin either way
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q <= `BUF_START;
      rd_q <= 9'h000;
      slip_repeat <= 1'b0;
      slip_delete <= 1'b0;
    end
    else
    begin
      slip_repeat <= 1'b0;
      slip_delete <= 1'b0;
      if (wr_en)
        wr_q <= wrap_add(wr_q, 9'h001);
      if (rd_en && rd_last)
      begin
        // Underrun: after the last held bit, step back so the latest block is sent again
        rd_q <= wrap_add(rd_q, rd_step + 9'h001);
        slip_repeat <= 1'b1;
      end
      else if (wr_en && wr_full)
      begin
        // Overrun: skip one block (a whole frame, or eight bits in octet mode); a frame slip re-centres reading
        // A bit read in this cycle is not part of the deleted block
        rd_q <= wrap_add(rd_q, rd_en ? step + 9'h001 : step);
        slip_delete <= 1'b1;
      end
      else if (rd_en)
        rd_q <= wrap_add(rd_q, 9'h001);
    end
  end
endmodule

// file: dv/map_sva.sv
`timescale 1ns/1ps
module map_sva (
  input logic ref_clk,
  input logic arst_n,
  input logic ref_timing,
  input logic octet_mode,
  input logic t1_rx_en,
  input logic e1_rx_en,
  input logic e1_tx_bit,
  input logic e1_tx_en,
  input logic e1_tx_sync,
  input logic t1_tx_en,
  input logic map_slip,
  input logic demap_slip
);
  logic [7:0] cnt_q;
  logic seen_q;
  wire [7:0] pos = cnt_q + 8'h01;
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      cnt_q <= 8'h00;
      seen_q <= 1'b0;
    end
    else if (e1_tx_en)
    begin
      cnt_q <= e1_tx_sync ? 8'h00 : pos;
      seen_q <= seen_q | e1_tx_sync;
    end
  logic [8:0] gap_q;
  logic slipped_q;
  // Cycles since the last map slip, saturating
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      gap_q <= 9'h000;
      slipped_q <= 1'b0;
    end
    else if (map_slip)
    begin
      gap_q <= 9'h000;
      slipped_q <= 1'b1;
    end
    else if (gap_q != 9'h1FF)
      gap_q <= gap_q + 9'h001;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_sync; e1_tx_sync |-> e1_tx_en && e1_tx_bit; endproperty
  a_sync: assert property (p_sync) else $error("frame start bad");
  property p_len; e1_tx_sync && seen_q |-> cnt_q == 8'hFF; endproperty
  a_len: assert property (p_len) else $error("frame length bad");
  property p_rsv; e1_tx_en && seen_q && !e1_tx_sync && (pos[7:3] == 5'h10 || pos[7:3] > 5'h1A) |-> e1_tx_bit; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved slot bad");
  property p_ts26; e1_tx_en && seen_q && pos[7:3] == 5'h1A && pos[2:0] != 3'h0 |-> e1_tx_bit; endproperty
  a_ts26: assert property (p_ts26) else $error("slot 26 fill bad");
  property p_le1; !ref_timing && e1_tx_en |-> $past(t1_rx_en) || $past(t1_rx_en, 2); endproperty
  a_le1: assert property (p_le1) else $error("e1 timing bad");
  property p_lt1; !ref_timing && t1_tx_en |-> $past(e1_rx_en); endproperty
  a_lt1: assert property (p_lt1) else $error("t1 timing bad");
  property p_nosl; !ref_timing |-> !(map_slip || demap_slip); endproperty
  a_nosl: assert property (p_nosl) else $error("slip in loop mode");
  property p_gap; $rose(map_slip) && !octet_mode |=> !map_slip [*8]; endproperty
  a_gap: assert property (p_gap) else $error("slips too close");
  property p_ogap; $rose(map_slip) && octet_mode |=> !map_slip [*7]; endproperty
  a_ogap: assert property (p_ogap) else $error("octet slips too close");
  property p_margin; map_slip && slipped_q && !octet_mode |-> gap_q >= 9'h0BE; endproperty
  a_margin: assert property (p_margin) else $error("frame slip margin too small");
endmodule
bind t1_into_e1_frame_mapper map_sva u_sva (.ref_clk, .arst_n, .ref_timing, .octet_mode, .t1_rx_en, .e1_rx_en,
  .e1_tx_bit, .e1_tx_en, .e1_tx_sync, .t1_tx_en, .map_slip, .demap_slip);

// file: dv/e1_far_end.sv
`timescale 1ns/1ps
module e1_far_end (
  input logic ref_clk,
  input logic arst_n,
  input logic tx_bit,
  input logic tx_en,
  input logic tx_sync,
  output logic rx_bit,
  output logic rx_en,
  output logic rx_sync
);
  // Loops the line back; data toggles between bits so a stale value never passes
  always @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      rx_en <= 1'b0;
      rx_sync <= 1'b0;
      rx_bit <= 1'b0;
    end
    else
    begin
      rx_en <= tx_en;
      rx_sync <= tx_sync;
      rx_bit <= tx_en ? tx_bit : ~rx_bit;
    end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
`include "t1_e1_map.vh"
module tb_top;
  logic ref_clk = 0, arst_n = 0, ref_timing = 0, octet_mode = 0, t1_rx_bit = 0, t1_rx_en = 0;
  logic ref_e1_en = 0, ref_t1_en = 0, chk = 0;
  wire e1_tx_bit, e1_tx_en, e1_tx_sync, t1_tx_bit, t1_tx_en, map_slip, demap_slip, e1_rx_bit, e1_rx_en, e1_rx_sync;
  int bad_count, comparisons, cyc, p, n, ph, fr, slips, q, late;
  logic [31:0] rs = 32'h0001783F;
  logic hist [0:8191];
  t1_into_e1_frame_mapper uut (.ref_clk, .arst_n, .ref_timing, .octet_mode, .t1_rx_bit, .t1_rx_en, .e1_rx_bit,
    .e1_rx_en, .e1_rx_sync, .ref_e1_en, .ref_t1_en, .e1_tx_bit, .e1_tx_en, .e1_tx_sync, .t1_tx_bit, .t1_tx_en,
    .map_slip, .demap_slip);
  e1_far_end far (.ref_clk, .arst_n, .tx_bit(e1_tx_bit), .tx_en(e1_tx_en), .tx_sync(e1_tx_sync),
    .rx_bit(e1_rx_bit), .rx_en(e1_rx_en), .rx_sync(e1_rx_sync));
  initial forever #20 ref_clk = ~ref_clk;
  function logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function logic exp_fas(input int f, input int k);
    logic [7:0] w;
    w = f[0] ? `NFAS_WORD : `FAS_WORD;
    return w[7 - k];
  endfunction
  task check(input string nm, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s exp %b seen %b", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Payload index p maps to input bit p-193, since the buffer starts one frame full
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      bad_count++;
      print_verdict;
    end
    if (chk && e1_tx_en)
    begin
      ph = e1_tx_sync ? 0 : ph + 1;
      fr += e1_tx_sync;
      if (ph < 8)
        check("ts0", e1_tx_bit, exp_fas(fr, ph));
      else if ((ph >= 8 && ph < 128) || (ph >= 136 && ph < 208) || ph == 208)
      begin
        if (p >= 193)
          check("payload", e1_tx_bit, hist[p - 193]);
        p++;
      end
      else
        check("idle", e1_tx_bit, 1'b1);
    end
    // Looped-back payload returns after two buffers, each starting one frame full
    if (chk && t1_tx_en)
    begin
      if (q >= 386)
        check("demap", t1_tx_bit, hist[q - 386]);
      q++;
    end
  end
  task run(input logic rt, input logic om, input int len);
    {arst_n, t1_rx_en, ref_e1_en, ref_t1_en} = 4'h0;
    {ref_timing, octet_mode, chk} = {rt, om, !rt};
    {ph, fr, p, n, slips, q, late} = {32'd0, -32'd1, 32'd0, 32'd0, 32'd0, 32'd0, 32'd0};
    repeat (12) @(posedge ref_clk);
    #1 arst_n = 1;
    for (int i = 0; i < len; i++)
    begin
      @(posedge ref_clk);
      #1 rs = xs(rs);
      t1_rx_en = !t1_rx_en && rs[4];
      t1_rx_bit = rs[0];
      // Fast reference drains the map buffer, then a slow one fills it, so both slip kinds occur
      {ref_e1_en, ref_t1_en} = {rt && (2 * i < len || &rs[7:5]), rt};
      slips += map_slip + demap_slip;
      if (4 * i >= 3 * len)
        late += map_slip;
      if (t1_rx_en)
      begin
        hist[n] = rs[0];
        n++;
      end
    end
    if (rt)
    begin
      check("slip", slips != 0, 1'b1);
      check("late slip", late != 0, 1'b1);
    end
    $display("test done timing %0d octet %0d", rt, om);
  endtask
  initial
  begin
    run(0, 0, 6000);
    run(1, 0, 4000);
    run(1, 1, 4000);
    print_verdict;
  end
endmodule
